// ---- ibcf_pkg.sv ----
// Purpose: shared constants and types of the byte clock forwarding block
// Assumes: 8-bit register port, 50 MHz system clock
// Notes:   one byte (lower and upper nibble) per instance
package ibcf_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] OFF_CTRL_LO = 4'h0;
  localparam logic [3:0] OFF_CTRL_HI = 4'h4;
  localparam logic [3:0] OFF_STATUS = 4'h8;
  localparam logic [3:0] OFF_METER = 4'hC;
  // ----------------------------------------------------------------
  // nibble control fields
  // ----------------------------------------------------------------
  localparam int CTRL_W = 5;
  localparam int F_TAKE_POS = 0;
  localparam int F_TAKE_NEG = 1;
  localparam int F_DRV_UP = 2;
  localparam int F_DRV_DN = 3;
  localparam int F_SLICE0_CLK = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  // level shown on a route that carries no clock
  localparam logic IDLE_LEVEL = 1'b1;
  // ----------------------------------------------------------------
  // link activity meter
  // ----------------------------------------------------------------
  localparam int METER_W = 8;
  localparam logic [METER_W-1:0] METER_RST = 8'h00;
  localparam int CLK_PERIOD_NS = 20;
  localparam int ACT_WINDOW_NS = 1000;
  localparam int ACT_CYC = ACT_WINDOW_NS / CLK_PERIOD_NS;
  localparam logic [7:0] ACT_CYC_V = 8'(ACT_CYC);
  // ----------------------------------------------------------------
  // capture clock source of a nibble
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SRC_IDLE = 4'h1,
    SRC_SLICE0 = 4'h2,
    SRC_EXT = 4'h4,
    SRC_NEIGH = 4'h8
  } ibcf_src_t;
endpackage

// ---- ibcf_link_meter.sv ----
// Purpose: counts edges of the link clock, hands the count over in gray
// Assumes: link clock may stop between frames
// Notes:   run level arrives from the system domain and is resynchronised
`timescale 1ns/1ps
module ibcf_link_meter
  import ibcf_pkg::*;
(
  input wire logic link_clk_in,
  input wire logic rst_in,
  input wire logic run_in,
  output logic [ibcf_pkg::METER_W-1:0] gray_out
);
  // ----------------------------------------------------------------
  // run level crossing
  // ----------------------------------------------------------------
  logic run_meta_q;
  logic run_q;
  logic [METER_W-1:0] count_q;

  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      run_meta_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      run_meta_q <= run_in;
      run_q <= run_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // counter; gray so only one bit moves per edge across the crossing
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_q <= METER_RST;
      gray_out <= METER_RST;
    end else if (run_q) begin
      count_q <= count_q + 8'h01;
      gray_out <= (count_q + 8'h01) ^ ((count_q + 8'h01) >> 1);
    end
  end
endmodule

// ---- ibcf_byte_route.sv ----
// Purpose: capture clock steering for one byte of an I/O bank
// Assumes: routed clocks are slow enough to be resampled at 50 MHz
// Notes:   unused route outputs rest high, matching a tied-high input
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module ibcf_byte_route
  import ibcf_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic [ibcf_pkg::ADDR_W-1:0] addr_in,
  input wire logic [ibcf_pkg::DATA_W-1:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [ibcf_pkg::DATA_W-1:0] rd_data_out,
  input wire logic link_clk_in,
  input wire logic slice0_pad_lo_in,
  input wire logic slice0_pad_hi_in,
  input wire logic byte_clock_in_lo_in,
  input wire logic byte_clock_in_hi_in,
  output logic capture_clock_lo_out,
  output logic capture_clock_hi_out,
  output logic byte_clock_out_up_lo_out,
  output logic byte_clock_out_up_hi_out,
  output logic byte_clock_out_down_lo_out,
  output logic byte_clock_out_down_hi_out,
  output logic link_active_out
);
  import ibcf_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // a half-set take pair would split the polarities; park it idle
  function automatic ibcf_src_t cap_src(input logic [CTRL_W-1:0] c);
    ibcf_src_t s;
    s = SRC_EXT;
    if (c[F_TAKE_POS] != c[F_TAKE_NEG]) begin
      s = SRC_IDLE;
    end else if (c[F_TAKE_POS]) begin
      s = SRC_NEIGH;
    end else if (c[F_SLICE0_CLK]) begin
      s = SRC_SLICE0;
    end
    return s;
  endfunction

  // clock a nibble holds: its own slice zero pin or the external input
  function automatic logic rx_level(input logic [CTRL_W-1:0] c,
                                    input logic pad,
                                    input logic ext);
    return c[F_SLICE0_CLK] ? pad : ext;
  endfunction

  function automatic logic cap_level(input ibcf_src_t s,
                                     input logic pad,
                                     input logic ext,
                                     input logic nb);
    logic v;
    v = IDLE_LEVEL;
    case (s)
      SRC_SLICE0: v = pad;
      SRC_EXT: v = ext;
      SRC_NEIGH: v = nb;
      default: v = IDLE_LEVEL;
    endcase
    return v;
  endfunction

  function automatic logic [METER_W-1:0] gray2bin(
      input logic [METER_W-1:0] g);
    logic [METER_W-1:0] b;
    b = g;
    for (int i = METER_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers: {ext_hi, ext_lo, pad_hi, pad_lo}
  // ----------------------------------------------------------------
  logic [3:0] pin_meta_q;
  logic [3:0] pin_q;
  logic [METER_W-1:0] gray_link;
  logic [METER_W-1:0] gray_meta_q;
  logic [METER_W-1:0] gray_q;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pin_meta_q <= 4'hF;
      pin_q <= 4'hF;
    end else if (clk_en_in) begin
      pin_meta_q <= {byte_clock_in_hi_in, byte_clock_in_lo_in,
                     slice0_pad_hi_in, slice0_pad_lo_in};
      pin_q <= pin_meta_q;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      gray_meta_q <= METER_RST;
      gray_q <= METER_RST;
    end else if (clk_en_in) begin
      gray_meta_q <= gray_link;
      gray_q <= gray_meta_q;
    end
  end

  ibcf_link_meter u_meter (
    .link_clk_in(link_clk_in),
    .rst_in(rst_in),
    .run_in(clk_en_in),
    .gray_out(gray_link)
  );

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_lo_q;
  logic [CTRL_W-1:0] ctrl_hi_q;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_lo_q <= CTRL_RST;
      ctrl_hi_q <= CTRL_RST;
    end else if (clk_en_in && wr_in) begin
      if (addr_in == OFF_CTRL_LO) begin
        ctrl_lo_q <= wr_data_in[CTRL_W-1:0];
      end else if (addr_in == OFF_CTRL_HI) begin
        ctrl_hi_q <= wr_data_in[CTRL_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // routing
  // ----------------------------------------------------------------
  ibcf_src_t src_lo;
  ibcf_src_t src_hi;
  logic rx_lo;
  logic rx_hi;

  always_comb begin
    src_lo = cap_src(ctrl_lo_q);
    src_hi = cap_src(ctrl_hi_q);
    // only the slice zero pin may be a clock input
    rx_lo = rx_level(ctrl_lo_q, pin_q[0], pin_q[2]);
    rx_hi = rx_level(ctrl_hi_q, pin_q[1], pin_q[3]);
  end

  // each nibble picks alone, so both directions can run at once
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      capture_clock_lo_out <= IDLE_LEVEL;
      capture_clock_hi_out <= IDLE_LEVEL;
    end else if (clk_en_in) begin
      capture_clock_lo_out <= cap_level(src_lo, pin_q[0], pin_q[2],
                                        rx_hi);
      capture_clock_hi_out <= cap_level(src_hi, pin_q[1], pin_q[3],
                                        rx_lo);
    end
  end

  // external input relays through when slice zero is not a clock
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      byte_clock_out_up_lo_out <= IDLE_LEVEL;
      byte_clock_out_up_hi_out <= IDLE_LEVEL;
      byte_clock_out_down_lo_out <= IDLE_LEVEL;
      byte_clock_out_down_hi_out <= IDLE_LEVEL;
    end else if (clk_en_in) begin
      byte_clock_out_up_lo_out <=
        ctrl_lo_q[F_DRV_UP] ? rx_lo : IDLE_LEVEL;
      byte_clock_out_up_hi_out <=
        ctrl_hi_q[F_DRV_UP] ? rx_hi : IDLE_LEVEL;
      byte_clock_out_down_lo_out <=
        ctrl_lo_q[F_DRV_DN] ? rx_lo : IDLE_LEVEL;
      byte_clock_out_down_hi_out <=
        ctrl_hi_q[F_DRV_DN] ? rx_hi : IDLE_LEVEL;
    end
  end

  // ----------------------------------------------------------------
  // link activity
  // ----------------------------------------------------------------
  // a stopped link clock is normal between frames; this only reports it
  logic [METER_W-1:0] meter_q;
  logic [7:0] idle_cnt_q;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      meter_q <= METER_RST;
      idle_cnt_q <= 8'h00;
      link_active_out <= 1'b0;
    end else if (clk_en_in) begin
      meter_q <= gray2bin(gray_q);
      if (gray2bin(gray_q) != meter_q) begin
        idle_cnt_q <= 8'h00;
        link_active_out <= 1'b1;
      end else if (idle_cnt_q < ACT_CYC_V) begin
        idle_cnt_q <= idle_cnt_q + 8'h01;
      end else begin
        link_active_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out <= 8'h00;
    end else if (clk_en_in) begin
      rd_data_out <= 8'h00;
      if (rd_in) begin
        if (addr_in == OFF_CTRL_LO) begin
          rd_data_out <= {3'h0, ctrl_lo_q};
        end else if (addr_in == OFF_CTRL_HI) begin
          rd_data_out <= {3'h0, ctrl_hi_q};
        end else if (addr_in == OFF_STATUS) begin
          rd_data_out <= {src_hi, src_lo};
        end else if (addr_in == OFF_METER) begin
          rd_data_out <= meter_q;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  slice0_lo_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    clk_en_in && src_lo == SRC_SLICE0 |=>
      capture_clock_lo_out == $past(pin_q[0]))
    else $error("lower capture does not follow its slice zero pin");

  take_lo_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    clk_en_in && ctrl_hi_q[F_TAKE_POS] && ctrl_hi_q[F_TAKE_NEG]
      && ctrl_lo_q[F_SLICE0_CLK] |=>
      capture_clock_hi_out == $past(pin_q[0]))
    else $error("upper nibble does not take the lower clock");

  lower_own_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    clk_en_in && ctrl_lo_q == 5'h10 && ctrl_hi_q == 5'h03
      |=> capture_clock_lo_out == capture_clock_hi_out)
    else $error("lower receiving split the byte clocks");

  upper_own_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    clk_en_in && ctrl_hi_q == 5'h10 && ctrl_lo_q == 5'h03
      |=> capture_clock_lo_out == $past(pin_q[1]))
    else $error("lower nibble does not take the upper clock");

  cross_both_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    clk_en_in && ctrl_lo_q == 5'h13 && ctrl_hi_q == 5'h13
      |=> capture_clock_lo_out == $past(pin_q[1])
        && capture_clock_hi_out == $past(pin_q[0]))
    else $error("crossed inter-nibble routes not both working");

  drive_up_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    clk_en_in |=> byte_clock_out_up_lo_out ==
      ($past(ctrl_lo_q[F_DRV_UP]) ? $past(rx_lo) : IDLE_LEVEL))
    else $error("upward output wrong for its enable");

  pass_down_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    clk_en_in && !ctrl_lo_q[F_SLICE0_CLK] && ctrl_lo_q[F_DRV_DN]
      |=> byte_clock_out_down_lo_out == $past(pin_q[2]))
    else $error("external clock not passed straight down");

  relay_cap_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    clk_en_in && src_hi == SRC_EXT
      |=> capture_clock_hi_out == $past(pin_q[3]))
    else $error("relaying nibble not capturing on external clock");

  upper_path_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    clk_en_in && ctrl_hi_q == 5'h08 && !ctrl_lo_q[F_TAKE_POS]
      |=> byte_clock_out_down_hi_out == $past(pin_q[3])
        && capture_clock_hi_out == $past(pin_q[3]))
    else $error("upper to upper route leaked through inter-nibble");

  split_take_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    clk_en_in && (ctrl_lo_q[F_TAKE_POS] != ctrl_lo_q[F_TAKE_NEG])
      |=> capture_clock_lo_out == IDLE_LEVEL)
    else $error("split take pair not parked idle");

  src_bank_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    clk_en_in && ctrl_lo_q == 5'h1C ##1 clk_en_in
      |-> byte_clock_out_up_lo_out == byte_clock_out_down_lo_out)
    else $error("source byte up and down outputs differ");

  multi_take_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    clk_en_in && ctrl_hi_q[F_TAKE_POS] && ctrl_hi_q[F_TAKE_NEG]
      && !ctrl_lo_q[F_TAKE_POS] && !ctrl_lo_q[F_TAKE_NEG] |=>
      capture_clock_hi_out == $past(rx_lo))
    else $error("upper nibble not fed from the lower nibble");

  dn_rest_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    clk_en_in && !ctrl_hi_q[F_DRV_DN] |=>
      byte_clock_out_down_hi_out == IDLE_LEVEL)
    else $error("disabled downward output not resting high");

  rd_idle_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    clk_en_in && !rd_in |=> rd_data_out == 8'h00)
    else $error("read data left standing without a read");

  en_freeze_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    !clk_en_in |=> $stable(capture_clock_lo_out)
      && $stable(capture_clock_hi_out) && $stable(ctrl_hi_q))
    else $error("state moved while clock enable low");

  lower_to_upper_c: cover property (@(posedge clock_in)
    ctrl_lo_q == 5'h10 && ctrl_hi_q == 5'h03);
  crossed_c: cover property (@(posedge clock_in)
    ctrl_lo_q == 5'h13 && ctrl_hi_q == 5'h13);
  pass_through_c: cover property (@(posedge clock_in)
    ctrl_lo_q == 5'h08 && $changed(byte_clock_out_down_lo_out));
  link_live_c: cover property (@(posedge clock_in)
    $rose(link_active_out));
  upper_to_lower_c: cover property (@(posedge clock_in)
    ctrl_hi_q == 5'h10 && ctrl_lo_q == 5'h03);
endmodule

// ---- ibcf_strobe_source.sv ----
// Purpose: far-side device model, sends a strobe beside its data
// Assumes: strobe and link clock stand still between frames
// Notes:   the data pin always shows the inverse of the strobe pin
`timescale 1ns/1ps
module ibcf_strobe_source (
  input wire logic run_in,
  input wire logic sel_hi_in,
  input wire logic lvl_in,
  output logic link_clk_out,
  output logic pad_lo_out,
  output logic pad_hi_out
);
  logic strobe;
  // ----------------------------------------------------------------
  // link clock, 64 ns, phase unrelated to the system clock
  // ----------------------------------------------------------------
  initial begin
    link_clk_out = 1'b0;
    #7;
    forever begin
      #32;
      link_clk_out = run_in ? ~link_clk_out : 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  // static level outside frames lets the bench check routes exactly
  assign strobe = run_in ? link_clk_out : lvl_in;
  // strobe only on a slice zero pin, the other one carries data
  assign pad_lo_out = sel_hi_in ? ~strobe : strobe;
  assign pad_hi_out = sel_hi_in ? strobe : ~strobe;
endmodule

// ---- ibcf_byte_route_tb.sv ----
// Purpose: self-checking bench of the byte clock steering block
// Assumes: routes checked with static levels, link meter with a frame
// Notes:   expected route levels come from a small nibble model below
`timescale 1ns/1ps
module ibcf_byte_route_tb;
  import ibcf_pkg::*;
  logic clock_in, rst_in, clk_en_in, wr_in, rd_in;
  logic [ADDR_W-1:0] addr_in;
  logic [DATA_W-1:0] wr_data_in, rd_data_out;
  logic link_clk, pad_lo, pad_hi, ext_lo, ext_hi, run, sel_hi, lvl;
  logic cap_lo, cap_hi, up_lo, up_hi, dn_lo, dn_hi, link_active;
  int n_fail = 0;
  int samples_checked = 0;
  // route cases: ctrl_lo, ctrl_hi, strobe on upper pin, ext lo/hi move
  localparam logic [12:0] CASES [8] = '{
    {5'h10, 5'h03, 3'b000},
    {5'h03, 5'h10, 3'b100},
    {5'h13, 5'h13, 3'b000},
    {5'h1C, 5'h03, 3'b000},
    {5'h08, 5'h03, 3'b010},
    {5'h00, 5'h08, 3'b001},
    {5'h10, 5'h01, 3'b000},
    {5'h10, 5'h16, 3'b100}
  };
  ibcf_strobe_source far_end (.run_in(run), .sel_hi_in(sel_hi),
    .lvl_in(lvl), .link_clk_out(link_clk), .pad_lo_out(pad_lo),
    .pad_hi_out(pad_hi));
  ibcf_byte_route dut (.clock_in(clock_in), .rst_in(rst_in),
    .clk_en_in(clk_en_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
    .link_clk_in(link_clk), .slice0_pad_lo_in(pad_lo),
    .slice0_pad_hi_in(pad_hi), .byte_clock_in_lo_in(ext_lo),
    .byte_clock_in_hi_in(ext_hi), .capture_clock_lo_out(cap_lo),
    .capture_clock_hi_out(cap_hi), .byte_clock_out_up_lo_out(up_lo),
    .byte_clock_out_up_hi_out(up_hi), .byte_clock_out_down_lo_out(dn_lo),
    .byte_clock_out_down_hi_out(dn_hi), .link_active_out(link_active));
  // ----------------------------------------------------------------
  // compare, bus and model tasks
  // ----------------------------------------------------------------
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1 chk_reg(rd_data_out, e);
  endtask
  // returns {source one-hot, capture, up, down} of one nibble
  function automatic logic [6:0] exp_nib(input logic [4:0] c,
      input logic [4:0] o, input logic p, po, e, eo);
    logic r, ro;
    r = c[4] ? p : e;
    ro = o[4] ? po : eo;
    exp_nib[1] = c[2] ? r : 1'b1;
    exp_nib[0] = c[3] ? r : 1'b1;
    case (c[1:0])
      2'b11: exp_nib[6:2] = {4'h8, ro};
      2'b00: exp_nib[6:2] = {(c[4] ? 4'h2 : 4'h4), r};
      default: exp_nib[6:2] = {4'h1, 1'b1};
    endcase
  endfunction
  task automatic check_route(input logic [12:0] k);
    logic [6:0] el, eh;
    el = exp_nib(k[12:8], k[7:3], pad_lo, pad_hi, ext_lo, ext_hi);
    eh = exp_nib(k[7:3], k[12:8], pad_hi, pad_lo, ext_hi, ext_lo);
    chk_pin(cap_lo, el[2]);
    chk_pin(cap_hi, eh[2]);
    chk_pin(up_lo, el[1]);
    chk_pin(up_hi, eh[1]);
    chk_pin(dn_lo, el[0]);
    chk_pin(dn_hi, eh[0]);
    rd_chk(OFF_STATUS, {eh[6:3], el[6:3]});
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end
  initial begin
    rst_in = 1'b1;
    clk_en_in = 1'b1;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 4'h0;
    wr_data_in = 8'h00;
    ext_lo = 1'b1;
    ext_hi = 1'b1;
    run = 1'b0;
    sel_hi = 1'b0;
    lvl = 1'b0;
    repeat (8) @(posedge clock_in);
    rst_in <= 1'b0;
    #1 chk_pin(cap_lo & cap_hi & up_lo & up_hi & dn_lo & dn_hi, 1'b1);
    chk_pin(link_active, 1'b0);
    rd_chk(OFF_CTRL_LO, 8'h00);
    rd_chk(OFF_CTRL_HI, 8'h00);
    rd_chk(OFF_STATUS, 8'h44);
    rd_chk(OFF_METER, 8'h00);
    $display("test reset done");
    // spare bits read 0, status is read-only, strays go nowhere
    wr(OFF_CTRL_LO, 8'hFF);
    rd_chk(OFF_CTRL_LO, 8'h1F);
    @(posedge clock_in);
    #1 chk_reg(rd_data_out, 8'h00);
    wr(OFF_STATUS, 8'h00);
    rd_chk(OFF_STATUS, 8'h48);
    wr(4'h2, 8'hAA);
    rd_chk(4'h1, 8'h00);
    rd_chk(OFF_CTRL_HI, 8'h00);
    @(posedge clock_in);
    clk_en_in <= 1'b0;
    wr(OFF_CTRL_HI, 8'h10);
    @(posedge clock_in);
    clk_en_in <= 1'b1;
    rd_chk(OFF_CTRL_HI, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      wr(OFF_CTRL_LO, {3'b000, CASES[i][12:8]});
      wr(OFF_CTRL_HI, {3'b000, CASES[i][7:3]});
      for (int l = 0; l < 2; l++) begin
        @(posedge clock_in);
        sel_hi <= CASES[i][2];
        lvl <= l[0];
        ext_lo <= CASES[i][1] ? l[0] : 1'b1;
        ext_hi <= CASES[i][0] ? l[0] : 1'b1;
        // two sync stages and the output register, plus margin
        repeat (5) @(posedge clock_in);
        #1 check_route(CASES[i]);
      end
    end
    $display("test routing done");
    // 37 link edges; the first two only bring the run level across
    @(posedge clock_in);
    run <= 1'b1;
    repeat (10) @(posedge link_clk);
    @(posedge clock_in);
    #1 chk_pin(link_active, 1'b1);
    repeat (27) @(posedge link_clk);
    run <= 1'b0;
    repeat (40) @(posedge clock_in);
    #1 chk_pin(link_active, 1'b1);
    repeat (25) @(posedge clock_in);
    #1 chk_pin(link_active, 1'b0);
    rd_chk(OFF_METER, 8'h23);
    $display("test link meter done");
    end_of_test();
  end
endmodule
